// ==== design/difm_mapper.sv ====
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// RL1: Each input has its own select code, acting only on that input's state.
// RL2: Software changes select codes only while the drive is stopped.
// RL3: Code 0 does nothing, but the input state stays readable in status.
// RL4: Code 1 active selects the second accel/decel pair, jog ramps excepted.
// RL5: Codes 1 and 6 are assigned to at most one input each; the select register accepts either code on both inputs.
// RL6: Code 2 active jogs at jog rate to jog frequency; release ramps to stop.
// RL7: A valid start command overrides any jog, jog forward or jog reverse request.
// RL8: Code 3 raises the auxiliary input fault when the input is removed.
// RL9: Code 4, the default, selects presets with priority over the reference source.
// RL10: Code 5 active makes the keypad the start and speed source.
// RL11: Code 6 active makes the communications device the command source.
// RL12: Code 7 active clears the active fault.
// RL13: Code 8 active forces ramp to stop, regardless of stop mode.
// RL14: Code 9 active forces coast to stop, regardless of stop mode.
// RL15: Code 10 active starts DC injection stop, regardless of stop mode.
// RL16: Codes 11 and 12 request forward and reverse jog, ramping to stop on release.
// RL17: Code 13 active picks the voltage analog reference, start source untouched.
// RL18: Code 14 active picks the current analog reference, start source untouched.
// RL19: Code 26 active inverts the scaling of the analog range in use.
// RL20: Reserved codes 15 to 25 and above 26 act like code 0.
module difm_mapper
    import difm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic [NUM_INPUTS-1:0] din,
    input  wire logic                  drive_running,
    input  wire logic                  start_valid,
    output logic                       accel2_sel,
    output logic                       jog_req,
    output logic                       jog_fwd_req,
    output logic                       jog_rev_req,
    output logic [NUM_INPUTS-1:0]      preset_sel,
    output logic                       preset_override,
    output logic                       local_src,
    output logic                       comm_src,
    output logic                       fault_clear,
    output logic                       ramp_stop,
    output logic                       coast_stop,
    output logic                       dcinj_stop,
    output logic                       volt_ref_sel,
    output logic                       curr_ref_sel,
    output logic                       analog_invert,
    output logic                       aux_fault_evt,
    output logic                       aux_fault_flag
);

    // Offsets are 8-bit constants, so a narrower bus could not reach them
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_bad
        $error("difm_mapper: ADDR_W must be 8 to 32");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input sampling and select registers

    logic [NUM_INPUTS-1:0] din_r;
    logic [NUM_INPUTS-1:0] din_prev_r;
    logic [SEL_W-1:0]      sel_r [NUM_INPUTS];
    logic [RQ_W-1:0]       req_r;
    logic [RQ_W-1:0]       req_nxt;
    logic                  aux_fall;
    logic                  setup_wr;
    logic                  addr_sel;
    logic                  addr_status;
    logic                  addr_req;
    logic                  addr_fault;
    logic                  addr_ok;
    logic                  sel_refused;
    logic [NUM_INPUTS-1:0] sel_inert;

    always_ff @(posedge clock) begin
        if (reset) begin
            din_r      <= '0;
            din_prev_r <= '0;
        end else begin
            din_r      <= din;
            din_prev_r <= din_r;
        end
    end

    assign setup_wr    = psel && !penable && pwrite;
    assign addr_sel    = paddr == ADDR_W'(OFF_SELECT);
    assign addr_status = paddr == ADDR_W'(OFF_STATUS);
    assign addr_req    = paddr == ADDR_W'(OFF_REQUEST);
    assign addr_fault  = paddr == ADDR_W'(OFF_FAULT);
    assign addr_ok     = addr_sel || addr_status || addr_req || addr_fault;
    // Changing a function under a running motor could drop a stop or jog mid-ramp
    assign sel_refused = addr_sel && drive_running;

    always_ff @(posedge clock) begin
        if (reset) begin
            sel_r[0] <= SEL_RESET;
            sel_r[1] <= SEL_RESET;
        end else if (setup_wr && addr_sel && !drive_running) begin // RL2
            sel_r[0] <= pwdata[SEL1_LSB +: SEL_W];
            sel_r[1] <= pwdata[SEL2_LSB +: SEL_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Function decode; unknown codes match no entry and do nothing

    function automatic logic hit(input logic [4:0] code);
        logic any;
        any = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (din_r[i] && sel_r[i] == code) begin // RL1 RL20
                any = 1'b1;
            end
        end
        return any;
    endfunction

    always_comb begin
        req_nxt              = '0;
        req_nxt[RQ_ACC2]     = hit(FN_ACC2_DEC2); // RL4
        req_nxt[RQ_JOG]      = hit(FN_JOG) && !start_valid; // RL6 RL7
        req_nxt[RQ_JOG_FWD]  = hit(FN_JOG_FWD) && !start_valid; // RL16 RL7
        req_nxt[RQ_JOG_REV]  = hit(FN_JOG_REV) && !start_valid; // RL16 RL7
        req_nxt[RQ_PRESET]   = hit(FN_PRESET); // RL9
        req_nxt[RQ_LOCAL]    = hit(FN_LOCAL); // RL10
        req_nxt[RQ_COMM]     = hit(FN_COMM); // RL11
        req_nxt[RQ_CLR_FLT]  = hit(FN_CLEAR_FAULT); // RL12
        req_nxt[RQ_RAMP]     = hit(FN_RAMP_STOP); // RL13
        req_nxt[RQ_COAST]    = hit(FN_COAST_STOP); // RL14
        req_nxt[RQ_DCINJ]    = hit(FN_DCINJ_STOP); // RL15
        req_nxt[RQ_VREF]     = hit(FN_VOLT_REF); // RL17
        req_nxt[RQ_IREF]     = hit(FN_CURR_REF); // RL18
        req_nxt[RQ_INVERT]   = hit(FN_ANLG_INVERT); // RL19
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            req_r <= '0;
        end else begin
            req_r <= req_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            preset_sel <= '0;
        end else begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                preset_sel[i] <= din_r[i] && sel_r[i] == FN_PRESET; // RL9
            end
        end
    end

    assign accel2_sel      = req_r[RQ_ACC2];
    assign jog_req         = req_r[RQ_JOG];
    assign jog_fwd_req     = req_r[RQ_JOG_FWD];
    assign jog_rev_req     = req_r[RQ_JOG_REV];
    assign preset_override = req_r[RQ_PRESET];
    assign local_src       = req_r[RQ_LOCAL];
    assign comm_src        = req_r[RQ_COMM];
    assign fault_clear     = req_r[RQ_CLR_FLT];
    assign ramp_stop       = req_r[RQ_RAMP];
    assign coast_stop      = req_r[RQ_COAST];
    assign dcinj_stop      = req_r[RQ_DCINJ];
    assign volt_ref_sel    = req_r[RQ_VREF];
    assign curr_ref_sel    = req_r[RQ_IREF];
    assign analog_invert   = req_r[RQ_INVERT];

    ////////////////////////////////////////////////////////////////////////////////
    // Auxiliary fault: removal of an input selected to code 3 raises it

    always_comb begin
        aux_fall = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (din_prev_r[i] && !din_r[i] && sel_r[i] == FN_AUX_FAULT) begin // RL8
                aux_fall = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            aux_fault_evt <= 1'b0;
        end else begin
            aux_fault_evt <= aux_fall; // RL8
        end
    end

    // A new removal wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            aux_fault_flag <= 1'b0;
        end else if (aux_fall) begin
            aux_fault_flag <= 1'b1; // RL8
        end else if (req_nxt[RQ_CLR_FLT]) begin
            aux_fault_flag <= 1'b0; // RL12
        end else if (setup_wr && addr_fault && pwdata[FLT_AUX_BIT]) begin
            aux_fault_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: answer given in the first access cycle, no wait states

    always_ff @(posedge clock) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (!addr_ok || (pwrite && sel_refused));
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (addr_sel) begin
                prdata[SEL1_LSB +: SEL_W] <= sel_r[0];
                prdata[SEL2_LSB +: SEL_W] <= sel_r[1];
            end else if (addr_status) begin
                prdata[NUM_INPUTS-1:0] <= din_r; // RL3
            end else if (addr_req) begin
                prdata[RQ_W-1:0] <= req_r;
            end else if (addr_fault) begin
                prdata[FLT_AUX_BIT] <= aux_fault_flag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    // Codes that must leave every request low: unused and reserved
    always_comb begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
            sel_inert[i] = sel_r[i] == FN_NOT_USED
                           || (sel_r[i] > FN_CURR_REF && sel_r[i] != FN_ANLG_INVERT);
        end
    end

    sel_hold_a: assert property (@(posedge clock) disable iff (reset) // RL2
        drive_running |=> $stable(sel_r[0]) && $stable(sel_r[1]))
        else $error("select changed while running");

    status_pin_a: assert property (@(posedge clock) disable iff (reset) // RL3
        (psel && !penable && !pwrite && addr_status)
            |=> prdata[NUM_INPUTS-1:0] == $past(din_r))
        else $error("status lost input");

    acc2_map_a: assert property (@(posedge clock) disable iff (reset) // RL4
        (din_r[0] && sel_r[0] == FN_ACC2_DEC2) |=> accel2_sel)
        else $error("second ramp pair not selected");

    jog_start_a: assert property (@(posedge clock) disable iff (reset) // RL7
        start_valid |=> !jog_req && !jog_fwd_req && !jog_rev_req)
        else $error("jog not overridden by start");

    jog_map_a: assert property (@(posedge clock) disable iff (reset) // RL6
        ((din_r[0] && sel_r[0] == FN_JOG || din_r[1] && sel_r[1] == FN_JOG)
         && !start_valid) |=> jog_req)
        else $error("jog request missing");

    aux_fault_a: assert property (@(posedge clock) disable iff (reset) // RL8
        (sel_r[1] == FN_AUX_FAULT && $fell(din_r[1])) |=> aux_fault_evt && aux_fault_flag)
        else $error("aux fault not raised on removal");

    preset_map_a: assert property (@(posedge clock) disable iff (reset) // RL9
        preset_override |-> $past(din_r[0] && sel_r[0] == FN_PRESET
                                   || din_r[1] && sel_r[1] == FN_PRESET))
        else $error("preset override without cause");

    stop_map_a: assert property (@(posedge clock) disable iff (reset) // RL13
        ramp_stop |-> $past(din_r[0] && sel_r[0] == FN_RAMP_STOP
                             || din_r[1] && sel_r[1] == FN_RAMP_STOP))
        else $error("ramp stop without cause");

    coast_map_a: assert property (@(posedge clock) disable iff (reset) // RL14
        (din_r[0] && sel_r[0] == FN_COAST_STOP || din_r[1] && sel_r[1] == FN_COAST_STOP)
            |=> coast_stop)
        else $error("coast stop not forced");

    dcinj_map_a: assert property (@(posedge clock) disable iff (reset) // RL15
        (din_r[0] && sel_r[0] == FN_DCINJ_STOP || din_r[1] && sel_r[1] == FN_DCINJ_STOP)
            |=> dcinj_stop)
        else $error("dc injection stop not forced");

    unused_code_a: assert property (@(posedge clock) disable iff (reset) // RL20
        (sel_inert == '1) |=> req_r == '0 && preset_sel == '0)
        else $error("reserved code acted");

    apb_answer_a: assert property (@(posedge clock) disable iff (reset)
        (psel && !penable) |=> pready)
        else $error("apb answer late");

endmodule

// ==== design/difm_pkg.sv ====
package difm_pkg;

    // Function select codes carried by each input's select field
    typedef enum logic [4:0] {
        FN_NOT_USED    = 5'h00,
        FN_ACC2_DEC2   = 5'h01,
        FN_JOG         = 5'h02,
        FN_AUX_FAULT   = 5'h03,
        FN_PRESET      = 5'h04,
        FN_LOCAL       = 5'h05,
        FN_COMM        = 5'h06,
        FN_CLEAR_FAULT = 5'h07,
        FN_RAMP_STOP   = 5'h08,
        FN_COAST_STOP  = 5'h09,
        FN_DCINJ_STOP  = 5'h0A,
        FN_JOG_FWD     = 5'h0B,
        FN_JOG_REV     = 5'h0C,
        FN_VOLT_REF    = 5'h0D,
        FN_CURR_REF    = 5'h0E,
        FN_ANLG_INVERT = 5'h1A
    } difm_func_t;

    localparam int          SEL_W        = 5;
    localparam int          NUM_INPUTS   = 2;
    localparam logic [4:0]  SEL_RESET    = 5'h04;

    // Register byte offsets
    localparam logic [7:0]  OFF_SELECT   = 8'h00;
    localparam logic [7:0]  OFF_STATUS   = 8'h04;
    localparam logic [7:0]  OFF_REQUEST  = 8'h08;
    localparam logic [7:0]  OFF_FAULT    = 8'h0C;

    // Field positions in the select register
    localparam int          SEL1_LSB     = 0;
    localparam int          SEL2_LSB     = 8;

    // Field positions in the fault register
    localparam int          FLT_AUX_BIT  = 0;

    // Bit positions in the request register
    localparam int          RQ_ACC2      = 0;
    localparam int          RQ_JOG       = 1;
    localparam int          RQ_JOG_FWD   = 2;
    localparam int          RQ_JOG_REV   = 3;
    localparam int          RQ_PRESET    = 4;
    localparam int          RQ_LOCAL     = 5;
    localparam int          RQ_COMM      = 6;
    localparam int          RQ_CLR_FLT   = 7;
    localparam int          RQ_RAMP      = 8;
    localparam int          RQ_COAST     = 9;
    localparam int          RQ_DCINJ     = 10;
    localparam int          RQ_VREF      = 11;
    localparam int          RQ_IREF      = 12;
    localparam int          RQ_INVERT    = 13;
    localparam int          RQ_W         = 14;

endpackage

// ==== testbench/difm_mapper_bench.sv ====
`timescale 1ns/1ps
module difm_mapper_bench;
    import difm_pkg::*;
logic                  clock = 1'b0;
logic                  reset, psel, penable, pwrite, pready, pslverr;
logic [7:0]            paddr;
logic [31:0]           pwdata, prdata, rd, sel_now;
logic                  err, run_req, start_valid, drive_running;
logic [NUM_INPUTS-1:0] want, din, preset_sel;
logic                  accel2_sel, jog_req, jog_fwd_req, jog_rev_req, preset_override;
logic                  local_src, comm_src, fault_clear, ramp_stop, coast_stop, dcinj_stop;
logic                  volt_ref_sel, curr_ref_sel, analog_invert, aux_fault_evt, aux_fault_flag;
logic [RQ_W-1:0]       req_o;
logic [4:0]            code;
logic [4:0]            jog_codes [3] = '{5'h02, 5'h0B, 5'h0C};
int                    n_mismatch, checks_done, n_evt = 0, exp_evt;
////////////////////////////////////////////////////////////////////////////////
always #12.5 clock = ~clock;
assign req_o = {analog_invert, curr_ref_sel, volt_ref_sel, dcinj_stop, coast_stop, ramp_stop,
    fault_clear, comm_src, local_src, preset_override, jog_rev_req, jog_fwd_req, jog_req,
    accel2_sel};
always @(posedge clock) begin
    if (aux_fault_evt === 1'b1) begin
        n_evt <= n_evt + 1;
    end
end
difm_mapper dut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .din, .drive_running, .start_valid, .accel2_sel, .jog_req, .jog_fwd_req,
    .jog_rev_req, .preset_sel, .preset_override, .local_src, .comm_src, .fault_clear,
    .ramp_stop, .coast_stop, .dcinj_stop, .volt_ref_sel, .curr_ref_sel, .analog_invert,
    .aux_fault_evt, .aux_fault_flag);
difm_switches sw (.clock, .reset, .want, .run_req, .din, .drive_running);
////////////////////////////////////////////////////////////////////////////////
task automatic stop_test;
    if (n_mismatch == 0 && checks_done > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
        n_mismatch++;
        $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
endtask
// The wait is bounded so a slave that never answers ends the run
task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
        @(posedge clock);
        n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
        n_mismatch++;
        $display("MISMATCH at %0t: no ready", $time);
        stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
// Three edges to the outputs, two more so the event counter has settled
task automatic set_din(input logic [1:0] v);
    @(posedge clock);
    want <= v;
    repeat (5) @(posedge clock);
endtask
function automatic logic [RQ_W-1:0] exp_req(input logic [4:0] c);
    logic [RQ_W-1:0] m;
    m = '0;
    case (c)
        5'h01: m[RQ_ACC2] = 1'b1;
        5'h02: m[RQ_JOG] = 1'b1;
        5'h04: m[RQ_PRESET] = 1'b1;
        5'h05: m[RQ_LOCAL] = 1'b1;
        5'h06: m[RQ_COMM] = 1'b1;
        5'h07: m[RQ_CLR_FLT] = 1'b1;
        5'h08: m[RQ_RAMP] = 1'b1;
        5'h09: m[RQ_COAST] = 1'b1;
        5'h0A: m[RQ_DCINJ] = 1'b1;
        5'h0B: m[RQ_JOG_FWD] = 1'b1;
        5'h0C: m[RQ_JOG_REV] = 1'b1;
        5'h0D: m[RQ_VREF] = 1'b1;
        5'h0E: m[RQ_IREF] = 1'b1;
        5'h1A: m[RQ_INVERT] = 1'b1;
        default: m = '0;
    endcase
    return m;
endfunction
////////////////////////////////////////////////////////////////////////////////
initial begin
    reset = 1'b1;
    {psel, penable, pwrite, run_req, start_valid} = '0;
    paddr = '0;
    pwdata = '0;
    want = '0;
    n_mismatch = 0;
    checks_done = 0;
    exp_evt = 0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, OFF_SELECT, 32'h0);
    chk(rd, (32'(SEL_RESET) << SEL2_LSB) | (32'(SEL_RESET) << SEL1_LSB), "select reset");
    apb(1'b0, OFF_REQUEST, 32'h0);
    chk(rd, 32'h0, "request reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    // Codes 1 and 6 never sit on both inputs: the other one is always 0 here
    for (int i = 0; i < NUM_INPUTS; i++) begin
        for (int c = 0; c < 32; c++) begin
            code = 5'(c);
            apb(1'b1, OFF_SELECT, 32'(code) << (i ? SEL2_LSB : SEL1_LSB));
            set_din(2'(1 << (1 - i)));
            chk(32'(req_o), 32'h0, "other terminal");
            apb(1'b0, OFF_STATUS, 32'h0);
            chk(rd, 32'(1 << (1 - i)), "status");
            set_din(2'h3);
            chk(32'(req_o), 32'(exp_req(code)), "requests");
            chk(32'(preset_sel), (code == 5'h04) ? 32'(1 << i) : 32'h0, "preset");
            apb(1'b0, OFF_REQUEST, 32'h0);
            chk(rd, 32'(exp_req(code)), "request reg");
            set_din(2'h0);
            exp_evt += (code == 5'h03) ? 1 : 0;
            chk(32'(n_evt), 32'(exp_evt), "fault events");
            chk({31'h0, aux_fault_flag}, {31'h0, code == 5'h03}, "fault flag");
            apb(1'b1, OFF_FAULT, 32'h1);
        end
    end
    foreach (jog_codes[j]) begin
        apb(1'b1, OFF_SELECT, 32'(jog_codes[j]));
        start_valid <= 1'b1;
        set_din(2'h1);
        chk(32'(req_o), 32'h0, "jog under start");
        start_valid <= 1'b0;
        set_din(2'h1);
        chk(32'(req_o), 32'(exp_req(jog_codes[j])), "jog alone");
        set_din(2'h0);
    end
    apb(1'b1, OFF_SELECT, 32'h0000_0703);
    set_din(2'h1);
    set_din(2'h0);
    chk({31'h0, aux_fault_flag}, 32'h1, "fault before clear");
    set_din(2'h2);
    chk({31'h0, aux_fault_flag}, 32'h0, "fault cleared by input");
    set_din(2'h0);
    run_req <= 1'b1;
    set_din(2'h0);
    apb(1'b1, OFF_SELECT, 32'h0);
    chk({31'h0, err}, 32'h1, "write while running");
    apb(1'b0, OFF_SELECT, 32'h0);
    chk(rd, 32'h0000_0703, "codes kept");
    stop_test();
end
endmodule

// ==== testbench/difm_switches.sv ====
`timescale 1ns/1ps
// Field contacts and drive run state as seen from the terminals
module difm_switches
    import difm_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic [NUM_INPUTS-1:0] want,
    input  wire logic                  run_req,
    output logic      [NUM_INPUTS-1:0] din,
    output logic                       drive_running
);
////////////////////////////////////////////////////////////////////////////////
// Contacts are sampled once per edge with no debounce, so a bounce seen at an edge reaches the block
always_ff @(posedge clock) begin
    if (reset) begin
        din <= '0;
    end else begin
        din <= want;
    end
end
////////////////////////////////////////////////////////////////////////////////
// Select codes are only rewritten while this stays low
always_ff @(posedge clock) begin
    if (reset) begin
        drive_running <= 1'b0;
    end else begin
        drive_running <= run_req;
    end
end
endmodule
